//--- lbm_defines.vh
/*
 * Constants for the leaky-bucket input monitor: register offsets,
 * reset values, field positions and timing figures.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef LBM_DEFINES_VH
`define LBM_DEFINES_VH

// Register byte offsets on the APB
`define LBM_OFF_FILL_LIMIT    8'h00
`define LBM_OFF_LEAK_RATE     8'h04
`define LBM_OFF_UPPER_THR     8'h08
`define LBM_OFF_LOWER_THR     8'h0C
`define LBM_OFF_LEVEL         8'h10
`define LBM_OFF_IRQ_STATUS    8'h14
`define LBM_OFF_IRQ_MASK      8'h18
`define LBM_OFF_CTRL          8'h1C

// Reset values
`define LBM_RST_FILL_LIMIT    8'h08
`define LBM_RST_LEAK_RATE     8'h01
`define LBM_RST_UPPER_THR     8'h06
`define LBM_RST_LOWER_THR     8'h04
`define LBM_RST_IRQ_MASK      3'h0
`define LBM_RST_CTRL          1'h1

// Field positions
`define LBM_LEAK_RATE_MSB     1
`define LBM_LEAK_RATE_LSB     0
`define LBM_IRQ_ALARM_SET     0
`define LBM_IRQ_ALARM_CLR     1
`define LBM_IRQ_SATURATED     2
`define LBM_IRQ_W             3

// Timing: monitoring cycle in ms, clock in kHz
`define LBM_CYCLE_MS          128
`define LBM_CLK_KHZ           250000

`endif

//--- lbm_cycle_timer.v
/*
 * Monitoring cycle timer: divides pclk into a one-cycle enable pulse
 * once per monitoring cycle.
 * Assumes pclk at the rate the top-level parameter describes.
 */
`timescale 1ns/1ns
`default_nettype none
`include "lbm_defines.vh"

module lbm_cycle_timer #(
    parameter integer CYCLE_CLKS = (`LBM_CYCLE_MS * `LBM_CLK_KHZ) // Clocks per monitoring cycle
) (
    input  wire pclk,                           // System clock
    input  wire presetn,                        // Async reset, active low
    input  wire enable,                         // Timer runs while high
    output reg  tick                            // One-cycle pulse per cycle
);

    reg [31:0] count_r;

    // Free-running divider; held at zero while disabled so a restart is a full cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_r <= 32'h00000000;
            tick    <= 1'b0;
        end else if (!enable) begin
            count_r <= 32'h00000000;
            tick    <= 1'b0;
        end else if (count_r == CYCLE_CLKS - 1) begin
            count_r <= 32'h00000000;
            tick    <= 1'b1;
        end else begin
            count_r <= count_r + 32'h00000001;
            tick    <= 1'b0;
        end
    end

endmodule
`default_nettype wire

//--- lbm_bucket.v
/*
 * Leaky-bucket input monitor for one reference input, configuration 1.
 * Holds the fill, leak, threshold, interrupt and control registers on an
 * APB slave and grades the input once per monitoring cycle.
 * Assumes fault_in and erratic_in are asynchronous levels from the input
 * checker, held high for as long as the condition persists.
 */
// Function
// RULE1 - Add one to the bucket each monitoring cycle with a failed/erratic input.
// RULE2 - Subtract one per complete clean leak period of 1, 2, 4 or 8 cycles.
// RULE3 - Leak-rate bits [1:0] pick 128, 256, 512 or 1024 ms per decrement.
// RULE4 - Fill limit caps the bucket; no further increments once reached.
// RULE5 - Leak-rate byte is read/write, resets to 0000 0001, two bits used.
// RULE6 - Drain matches fill rate or one half, quarter or eighth of it.
// RULE7 - Fill and leak decisions are made once per 128 ms monitoring cycle.
// RULE8 - Raise the activity alarm when the bucket reaches the upper threshold.
// RULE9 - Clear the activity alarm when the bucket falls to the lower threshold.
// RULE10 - The bucket never goes below zero; leaks at zero change nothing.
`timescale 1ns/1ns
`default_nettype none
`include "lbm_defines.vh"

module lbm_bucket #(
    parameter integer CYCLE_CLKS = (`LBM_CYCLE_MS * `LBM_CLK_KHZ) // Clocks per cycle
) (
    input  wire        pclk,                    // APB clock, 250 MHz
    input  wire        presetn,                 // Async reset, active low
    input  wire        psel,                    // APB select
    input  wire        penable,                 // APB access phase
    input  wire        pwrite,                  // APB write
    input  wire [7:0]  paddr,                   // APB byte address
    input  wire [31:0] pwdata,                  // APB write data
    output reg  [31:0] prdata,                  // APB read data
    output wire        pready,                  // APB ready, always one
    output wire        pslverr,                 // APB error on unmapped address
    input  wire        fault_in,                // Input failed, async level
    input  wire        erratic_in,              // Input erratic, async level
    output reg         alarm,                   // Activity alarm level
    output reg  [7:0]  level,                   // Bucket contents
    output wire        irq                      // Interrupt, active high level
);

    // Registers
    reg [7:0]           fill_limit_r;
    reg [7:0]           leak_rate_r;
    reg [7:0]           upper_thr_r;
    reg [7:0]           lower_thr_r;
    reg [`LBM_IRQ_W-1:0] irq_status_r;
    reg [`LBM_IRQ_W-1:0] irq_mask_r;
    reg                 enable_r;

    // Synchronisers and per-cycle fault memory
    reg [1:0] fault_sync_r;
    reg [1:0] erratic_sync_r;
    reg       seen_bad_r;
    reg [2:0] clean_cnt_r;
    reg       alarm_nxt;
    reg [7:0] level_nxt;
    reg [2:0] clean_nxt;
    reg [`LBM_IRQ_W-1:0] irq_evt;

    wire tick;
    wire bad_now;
    wire wr_en;
    wire rd_en;
    wire [2:0] period_last;

    // Decode an address to a mapped-register hit
    function addr_hit;
        input [7:0] a;
        begin
            addr_hit = (a == `LBM_OFF_FILL_LIMIT) || (a == `LBM_OFF_LEAK_RATE) ||
                       (a == `LBM_OFF_UPPER_THR)  || (a == `LBM_OFF_LOWER_THR) ||
                       (a == `LBM_OFF_LEVEL)      || (a == `LBM_OFF_IRQ_STATUS) ||
                       (a == `LBM_OFF_IRQ_MASK)   || (a == `LBM_OFF_CTRL);
        end
    endfunction

    // Zero-wait-state slave; unmapped offsets answer with pslverr
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~addr_hit(paddr);
    assign wr_en   = psel & penable & pwrite & addr_hit(paddr);
    assign rd_en   = psel & ~penable & ~pwrite;

    // Monitoring cycle pulse
    lbm_cycle_timer #(
        .CYCLE_CLKS (CYCLE_CLKS)
    ) u_timer (
        .pclk    (pclk),
        .presetn (presetn),
        .enable  (enable_r),
        .tick    (tick)
    );

    // Two-flop synchronisers; only the second stage is read
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fault_sync_r   <= 2'h0;
            erratic_sync_r <= 2'h0;
        end else begin
            fault_sync_r   <= {fault_sync_r[0], fault_in};
            erratic_sync_r <= {erratic_sync_r[0], erratic_in};
        end
    end

    assign bad_now = fault_sync_r[1] | erratic_sync_r[1];

    // Leak period length minus one: 0, 1, 3 or 7 cycles
    assign period_last = (3'h1 << leak_rate_r[`LBM_LEAK_RATE_MSB:`LBM_LEAK_RATE_LSB]) - 3'h1; // RULE3 RULE6

    // Bucket update, evaluated once per monitoring cycle
    always @* begin
        level_nxt = level;
        clean_nxt = clean_cnt_r;
        alarm_nxt = alarm;
        irq_evt   = {`LBM_IRQ_W{1'b0}};
        if (tick) begin // RULE7
            if (seen_bad_r || bad_now) begin
                clean_nxt = 3'h0; // RULE2
                if (level < fill_limit_r) begin
                    level_nxt = level + 8'h01; // RULE1
                end else begin
                    irq_evt[`LBM_IRQ_SATURATED] = 1'b1; // RULE4
                end
            end else if (clean_cnt_r >= period_last) begin
                clean_nxt = 3'h0;
                if (level != 8'h00) begin
                    level_nxt = level - 8'h01; // RULE2 RULE10
                end
            end else begin
                clean_nxt = clean_cnt_r + 3'h1;
            end
            if (!alarm && level_nxt >= upper_thr_r) begin
                alarm_nxt = 1'b1; // RULE8
                irq_evt[`LBM_IRQ_ALARM_SET] = 1'b1;
            end else if (alarm && level_nxt <= lower_thr_r) begin
                alarm_nxt = 1'b0; // RULE9
                irq_evt[`LBM_IRQ_ALARM_CLR] = 1'b1;
            end
        end
    end

    // Bucket state; a fault anywhere inside a cycle counts for that cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            level       <= 8'h00;
            clean_cnt_r <= 3'h0;
            alarm       <= 1'b0;
            seen_bad_r  <= 1'b0;
        end else if (!enable_r) begin
            level       <= 8'h00;
            clean_cnt_r <= 3'h0;
            alarm       <= 1'b0;
            seen_bad_r  <= 1'b0;
        end else begin
            level       <= level_nxt;
            clean_cnt_r <= clean_nxt;
            alarm       <= alarm_nxt;
            seen_bad_r  <= tick ? 1'b0 : (seen_bad_r | bad_now); // RULE1
        end
    end

    // Configuration registers; writes land in the access phase
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fill_limit_r <= `LBM_RST_FILL_LIMIT;
            leak_rate_r  <= `LBM_RST_LEAK_RATE; // RULE5
            upper_thr_r  <= `LBM_RST_UPPER_THR;
            lower_thr_r  <= `LBM_RST_LOWER_THR;
            irq_mask_r   <= `LBM_RST_IRQ_MASK;
            enable_r     <= `LBM_RST_CTRL;
        end else if (wr_en) begin
            case (paddr)
                `LBM_OFF_FILL_LIMIT: fill_limit_r <= pwdata[7:0]; // RULE4
                `LBM_OFF_LEAK_RATE:  leak_rate_r  <= pwdata[7:0]; // RULE5
                `LBM_OFF_UPPER_THR:  upper_thr_r  <= pwdata[7:0];
                `LBM_OFF_LOWER_THR:  lower_thr_r  <= pwdata[7:0];
                `LBM_OFF_IRQ_MASK:   irq_mask_r   <= pwdata[`LBM_IRQ_W-1:0];
                `LBM_OFF_CTRL:       enable_r     <= pwdata[0];
                default:             enable_r     <= enable_r;
            endcase
        end
    end

    // Sticky status, write one to clear; a same-cycle event wins over the clear
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status_r <= {`LBM_IRQ_W{1'b0}};
        end else begin
            irq_status_r <= (irq_status_r &
                             ~((wr_en && paddr == `LBM_OFF_IRQ_STATUS) ?
                               pwdata[`LBM_IRQ_W-1:0] : {`LBM_IRQ_W{1'b0}})) | irq_evt;
        end
    end

    assign irq = |(irq_status_r & irq_mask_r);

    // Read data registered in the setup phase, valid for the access phase
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (rd_en) begin
            case (paddr)
                `LBM_OFF_FILL_LIMIT: prdata <= {24'h000000, fill_limit_r};
                `LBM_OFF_LEAK_RATE:  prdata <= {24'h000000, leak_rate_r};
                `LBM_OFF_UPPER_THR:  prdata <= {24'h000000, upper_thr_r};
                `LBM_OFF_LOWER_THR:  prdata <= {24'h000000, lower_thr_r};
                `LBM_OFF_LEVEL:      prdata <= {23'h000000, alarm, level};
                `LBM_OFF_IRQ_STATUS: prdata <= {29'h00000000, irq_status_r};
                `LBM_OFF_IRQ_MASK:   prdata <= {29'h00000000, irq_mask_r};
                `LBM_OFF_CTRL:       prdata <= {31'h00000000, enable_r};
                default:             prdata <= 32'h00000000;
            endcase
        end
    end

endmodule
`default_nettype wire

//--- lbm_bucket_chk.sv
/* Concurrent checks on the leaky-bucket monitor ports.
   Assumes zero-wait APB and the map in lbm_defines.vh. */
`timescale 1ns/1ns
`default_nettype none
`include "lbm_defines.vh"
module lbm_bucket_chk #(
    parameter integer CYCLE_CLKS = (`LBM_CYCLE_MS * `LBM_CLK_KHZ)
) (
    input wire logic        pclk,       // Clock
    input wire logic        presetn,    // Reset
    input wire logic        psel,       // Select
    input wire logic        penable,    // Access
    input wire logic        pwrite,     // Write
    input wire logic [7:0]  paddr,      // Address
    input wire logic [31:0] pwdata,     // Wdata
    input wire logic [31:0] prdata,     // Rdata
    input wire logic        pready,     // Ready
    input wire logic        pslverr,    // Error
    input wire logic        fault_in,   // Fault
    input wire logic        erratic_in, // Erratic
    input wire logic        alarm,      // Alarm
    input wire logic [7:0]  level,      // Bucket
    input wire logic        irq         // Irq
);
    logic [7:0] lim_r, up_r, lo_r, rate_r, prev_r;
    logic       en_r;
    int         cnt_r;
    wire        wr = psel && penable && pwrite;
    // Shadow limits from writes; clocks since last level change, saturating
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lim_r <= `LBM_RST_FILL_LIMIT;
            up_r <= `LBM_RST_UPPER_THR;
            lo_r <= `LBM_RST_LOWER_THR;
            rate_r <= `LBM_RST_LEAK_RATE;
            prev_r <= 8'h00;
            en_r <= `LBM_RST_CTRL;
            cnt_r <= CYCLE_CLKS << 3;
        end else begin
            if (wr && paddr == `LBM_OFF_CTRL) en_r <= pwdata[0];
            if (wr && paddr == `LBM_OFF_FILL_LIMIT) lim_r <= pwdata[7:0];
            if (wr && paddr == `LBM_OFF_UPPER_THR) up_r <= pwdata[7:0];
            if (wr && paddr == `LBM_OFF_LOWER_THR) lo_r <= pwdata[7:0];
            if (wr && paddr == `LBM_OFF_LEAK_RATE) rate_r <= pwdata[7:0];
            prev_r <= level;
            cnt_r <= (level != prev_r) ? 1 : ((cnt_r < (CYCLE_CLKS << 3)) ? cnt_r + 1 : cnt_r);
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // A disable clears the bucket at once, so stepping and spacing hold only while enabled
    step_by_one_a: assert property ($changed(level) && en_r |->
        (level == $past(level) + 8'h01) || (level == $past(level) - 8'h01))
        else $error("level moved by more than one");
    fill_cap_a: assert property (level > $past(level) |-> $past(level) < lim_r)
        else $error("level rose past the fill limit");
    no_wrap_a: assert property ($past(level) == 8'h00 |-> level != 8'hFF)
        else $error("level wrapped below zero");
    fill_space_a: assert property ($changed(level) && en_r |-> cnt_r >= CYCLE_CLKS)
        else $error("level changed twice in one cycle");
    leak_space_a: assert property (level < $past(level) && en_r |->
        cnt_r >= (CYCLE_CLKS << rate_r[1:0])) else $error("leak came too early");
    alarm_set_a: assert property ($changed(level) && level >= up_r |-> alarm)
        else $error("alarm not raised at upper threshold");
    alarm_clr_a: assert property ($changed(level) && level <= lo_r |-> !alarm)
        else $error("alarm not cleared at lower threshold");
    alarm_cause_a: assert property ($changed(alarm) |-> $changed(level))
        else $error("alarm moved without a level change");
    rate_read_a: assert property (psel && penable && !pwrite &&
        paddr == `LBM_OFF_LEAK_RATE |-> prdata[7:0] == rate_r)
        else $error("leak rate readback wrong");
    disable_clear_a: assert property (!en_r && $past(!en_r) |->
        level == 8'h00 && !alarm) else $error("disable left bucket or alarm set");
endmodule
bind lbm_bucket lbm_bucket_chk #(.CYCLE_CLKS(CYCLE_CLKS)) lbm_bucket_chk_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fault_in(fault_in), .erratic_in(erratic_in), .alarm(alarm), .level(level), .irq(irq));
`default_nettype wire

//--- lbm_bucket_tb_top.sv
/* Self-checking bench for lbm_bucket driven over APB.
   Assumes a 16-clock monitoring cycle set through CYCLE_CLKS. */
`timescale 1ns/1ns
`default_nettype none
`include "lbm_defines.vh"
module lbm_bucket_tb_top;
    localparam int C = 16;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
    logic        fault_in = 0, erratic_in = 0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, rd;
    logic [7:0]  ra [8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h18, 8'h1C, 8'h10, 8'h14};
    logic [31:0] rv [8] = '{32'h08, 32'h01, 32'h06, 32'h04, 32'h00, 32'h01, 32'h00, 32'h00};
    wire  [31:0] prdata;
    wire  [7:0]  level;
    wire         pready, pslverr, alarm, irq;
    int          err_total = 0, checked = 0, n;
    lbm_bucket #(.CYCLE_CLKS(C)) lbm_bucket_i (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .fault_in(fault_in),
        .erratic_in(erratic_in), .alarm(alarm), .level(level), .irq(irq));
    initial forever #2 pclk = ~pclk;
    // One APB transfer; the request stands until pready is seen at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk) begin psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; end
        @(posedge pclk) penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            err_total++;
            $display("ERROR %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // Clocks until level moves, sampled on the falling edge where it is settled
    task automatic wchg;
        logic [7:0] o;
        o = level;
        n = 0;
        do begin @(negedge pclk); n++; end while (level === o && n < 4000);
    endtask
    task end_of_test;
        $display("checked %0d err_total %0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // A hang shows as a failed run, not a silent one
    initial begin
        #100000;
        err_total++;
        $display("ERROR %0t: watchdog expired", $time);
        end_of_test;
    end
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        foreach (ra[i]) begin apb(0, ra[i], 0); chk(rd, rv[i]); end
        apb(1, `LBM_OFF_LEAK_RATE, 32'hAA);
        apb(0, `LBM_OFF_LEAK_RATE, 0);
        chk(rd, 32'hAA);
        apb(0, 8'h20, 0);
        chk({err, rd[30:0]}, 32'h80000000);
        apb(1, `LBM_OFF_FILL_LIMIT, 5);
        apb(1, `LBM_OFF_UPPER_THR, 3);
        apb(1, `LBM_OFF_LOWER_THR, 1);
        // Each leak code in turn, fault and erratic inputs taking turns as cause
        for (int r = 0; r < 4; r++) begin
            apb(1, `LBM_OFF_LEAK_RATE, r);
            @(posedge pclk) begin fault_in <= ~r[0]; erratic_in <= r[0]; end
            wchg;
            repeat (4) begin wchg; chk(n, C); end
            chk({alarm, level}, {1'b1, 8'h05});
            repeat (3 * C) @(negedge pclk);
            chk(level, 5);
            apb(0, `LBM_OFF_IRQ_STATUS, 0);
            chk(rd, 32'h5);
            apb(1, `LBM_OFF_IRQ_MASK, 1);
            @(negedge pclk) chk(irq, 1);
            apb(1, `LBM_OFF_IRQ_MASK, 0);
            @(negedge pclk) chk(irq, 0);
            apb(1, `LBM_OFF_IRQ_MASK, 1);
            apb(1, `LBM_OFF_IRQ_STATUS, 1);
            @(negedge pclk) chk(irq, 0);
            @(posedge pclk) begin fault_in <= 1'b0; erratic_in <= 1'b0; end
            wchg;
            wchg;
            chk(n, C << r);
            chk({alarm, level}, {1'b1, 8'h03});
            wchg;
            wchg;
            chk({alarm, level}, {1'b0, 8'h01});
            wchg;
            repeat (3 * (C << r)) @(negedge pclk);
            chk(level, 0);
            apb(0, `LBM_OFF_IRQ_STATUS, 0);
            chk(rd, 32'h6);
            apb(1, `LBM_OFF_IRQ_STATUS, 7);
        end
        // Disable with a part-filled bucket: bucket and alarm must clear at once
        @(posedge pclk) fault_in <= 1'b1;
        repeat (4) wchg;
        apb(0, `LBM_OFF_LEVEL, 0);
        chk(rd, 32'h104);
        apb(1, `LBM_OFF_CTRL, 0);
        apb(0, `LBM_OFF_LEVEL, 0);
        chk(rd, 32'h0);
        @(posedge pclk) fault_in <= 1'b0;
        apb(1, `LBM_OFF_CTRL, 1);
        end_of_test;
    end
endmodule
`default_nettype wire
